// ### rtl/pioc_port.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module pioc_port
  import pioc_pkg::*;
#(
  parameter int PINS = pioc_pkg::PIOC_PINS
) (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            rst_b,
  // APB slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Pins
  input  wire logic [PINS-1:0] pinIn,
  output logic [PINS-1:0]      pinOut,
  output logic [PINS-1:0]      pinOe,
  output logic [PINS-1:0]      pullUpEn,
  output logic [PINS-1:0]      pullDownEn,
  // Analog side
  output logic [PINS-1:0]      analogSelect,
  output logic [PINS-1:0]      analogLevel,
  // Change notification
  output logic                 changeIrq
);
  import pioc_pkg::*;

  // ****************************************
  // Address decode
  // ****************************************
  typedef enum logic [3:0] {
    REG_NONE, REG_PIN, REG_ANA, REG_DIR, REG_LAT,
    REG_ODC, REG_PU, REG_PD, REG_CNEN, REG_CNST
  } pioc_reg_e;

  function automatic pioc_reg_e decodeReg(input logic [31:0] addr);
    logic [15:0] base;
    base = {addr[15:4], 4'h0};
    if (addr[31:16] != 16'h0000 || addr[1:0] != 2'b00) begin
      decodeReg = REG_NONE;
    end else if (base == PIOC_PIN_VALUE_OFS) begin
      decodeReg = REG_PIN;
    end else if (base == PIOC_ANALOG_SEL_OFS) begin
      decodeReg = REG_ANA;
    end else if (base == PIOC_DIRECTION_OFS) begin
      decodeReg = REG_DIR;
    end else if (base == PIOC_OUT_LATCH_OFS) begin
      decodeReg = REG_LAT;
    end else if (base == PIOC_OPEN_DRAIN_OFS) begin
      decodeReg = REG_ODC;
    end else if (base == PIOC_PULL_UP_OFS) begin
      decodeReg = REG_PU;
    end else if (base == PIOC_PULL_DOWN_OFS) begin
      decodeReg = REG_PD;
    end else if (base == PIOC_CHANGE_EN_OFS) begin
      decodeReg = REG_CNEN;
    end else if (base == PIOC_CHANGE_STAT_OFS) begin
      decodeReg = REG_CNST;
    end else begin
      decodeReg = REG_NONE;
    end
  endfunction

  function automatic pioc_op_e decodeOp(input logic [3:0] nib);
    if (nib == PIOC_ALIAS_CLR) begin
      decodeOp = PIOC_OP_CLR;
    end else if (nib == PIOC_ALIAS_SET) begin
      decodeOp = PIOC_OP_SET;
    end else if (nib == PIOC_ALIAS_TGL) begin
      decodeOp = PIOC_OP_TGL;
    end else begin
      decodeOp = PIOC_OP_WRITE;
    end
  endfunction

  function automatic logic [PINS-1:0] applyOp(
    input pioc_op_e        op,
    input logic [PINS-1:0] cur,
    input logic [PINS-1:0] wd
  );
    case (op)
      PIOC_OP_CLR: applyOp = cur & ~wd;
      PIOC_OP_SET: applyOp = cur | wd;
      PIOC_OP_TGL: applyOp = cur ^ wd;
      default:     applyOp = wd;
    endcase
  endfunction

  pioc_reg_e       regSel;
  pioc_op_e        regOp;
  logic            access;
  logic            wrEn;
  logic            setupRd;
  logic            pinRead;
  logic [PINS-1:0] wd;

  assign regSel = decodeReg(paddr);
  assign regOp  = decodeOp(paddr[3:0]);
  assign access = psel & penable;
  assign wrEn   = access & pwrite;
  // Pin sample and reference share one edge
  assign setupRd = psel & ~penable & ~pwrite;
  assign pinRead = setupRd & (regSel == REG_PIN) &
                   (regOp == PIOC_OP_WRITE);
  // Only low pin bits are stored
  assign wd     = pwdata[PINS-1:0];

  // ****************************************
  // Bus handshake
  // ****************************************
  // Zero wait states, read data set up early
  assign pready  = 1'b1;
  assign pslverr = access & (regSel == REG_NONE);

  // ****************************************
  // Registers
  // ****************************************
  logic [PINS-1:0] direction_q;
  logic [PINS-1:0] analogSel_q;
  logic [PINS-1:0] latch_q;
  logic [PINS-1:0] openDrain_q;
  logic [PINS-1:0] pullUp_q;
  logic [PINS-1:0] pullDown_q;
  logic [PINS-1:0] changeEn_q;
  logic [PINS-1:0] pinValue;
  logic [PINS-1:0] changeStatus;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      direction_q <= PIOC_DIRECTION_RST[PINS-1:0];
    end else if (wrEn && regSel == REG_DIR) begin
      direction_q <= applyOp(regOp, direction_q, wd);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      analogSel_q <= PIOC_ANALOG_SEL_RST[PINS-1:0];
    end else if (wrEn && regSel == REG_ANA) begin
      analogSel_q <= applyOp(regOp, analogSel_q, wd);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= PIOC_ZERO_RST[PINS-1:0];
    end else if (wrEn && (regSel == REG_LAT || regSel == REG_PIN)) begin
      latch_q <= applyOp(regOp, latch_q, wd);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      openDrain_q <= PIOC_ZERO_RST[PINS-1:0];
    end else if (wrEn && regSel == REG_ODC) begin
      openDrain_q <= applyOp(regOp, openDrain_q, wd);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pullUp_q <= PIOC_ZERO_RST[PINS-1:0];
    end else if (wrEn && regSel == REG_PU) begin
      pullUp_q <= applyOp(regOp, pullUp_q, wd);
    end
  end

  // Pull-down enables
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pullDown_q <= PIOC_ZERO_RST[PINS-1:0];
    end else if (wrEn && regSel == REG_PD) begin
      pullDown_q <= applyOp(regOp, pullDown_q, wd);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      changeEn_q <= PIOC_ZERO_RST[PINS-1:0];
    end else if (wrEn && regSel == REG_CNEN) begin
      changeEn_q <= applyOp(regOp, changeEn_q, wd);
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : gPin
      // Open drain floats the high level
      assign pinOe[g]  = ~direction_q[g] &
                         ~(openDrain_q[g] & latch_q[g]);
      assign pinOut[g] = latch_q[g];
      assign pinValue[g] = pinIn[g] &
                           ~(analogSel_q[g] & direction_q[g]);
    end
  endgenerate

  assign pullUpEn     = pullUp_q;
  assign pullDownEn   = pullDown_q;
  assign analogSelect = analogSel_q;
  // Driven level seen by analog side
  assign analogLevel  = (pinIn & direction_q) |
                        (latch_q & ~direction_q);

  // ****************************************
  // Change notification
  // ****************************************
  // Status since last pin-value read
  pioc_change_detect #(
    .WIDTH        (PINS)
  ) uChange (
    .mclk         (mclk),
    .rst_b        (rst_b),
    .pinLevel     (pinIn),
    .changeEnable (changeEn_q),
    .pinValueRead (pinRead),
    .changeStatus (changeStatus),
    .changeIrq    (changeIrq)
  );

  // ****************************************
  // Read data
  // ****************************************
  logic [PINS-1:0] rdVal;
  always_comb begin
    if (regSel == REG_PIN) begin
      rdVal = pinValue;
    end else if (regSel == REG_ANA) begin
      rdVal = analogSel_q;
    end else if (regSel == REG_DIR) begin
      rdVal = direction_q;
    end else if (regSel == REG_LAT) begin
      rdVal = latch_q;
    end else if (regSel == REG_ODC) begin
      rdVal = openDrain_q;
    end else if (regSel == REG_PU) begin
      rdVal = pullUp_q;
    end else if (regSel == REG_PD) begin
      rdVal = pullDown_q;
    end else if (regSel == REG_CNEN) begin
      rdVal = changeEn_q;
    end else if (regSel == REG_CNST) begin
      rdVal = changeStatus;
    end else begin
      rdVal = '0;
    end
  end

  // Upper bits read zero
  // Loaded at the setup edge, stands through the access cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (setupRd && regOp == PIOC_OP_WRITE) begin
      prdata <= {{(32-PINS){1'b0}}, rdVal};
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

endmodule

// ### common/pioc_pkg.sv
package pioc_pkg;

  // Register word addresses (APB byte addresses, low 16 bits)
  localparam logic [15:0] PIOC_PIN_VALUE_OFS    = 16'h5320;
  localparam logic [15:0] PIOC_ANALOG_SEL_OFS   = 16'h6300;
  localparam logic [15:0] PIOC_DIRECTION_OFS    = 16'h6310;
  localparam logic [15:0] PIOC_OUT_LATCH_OFS    = 16'h6330;
  localparam logic [15:0] PIOC_OPEN_DRAIN_OFS   = 16'h6340;
  localparam logic [15:0] PIOC_PULL_UP_OFS      = 16'h6350;
  localparam logic [15:0] PIOC_PULL_DOWN_OFS    = 16'h6360;
  localparam logic [15:0] PIOC_CHANGE_EN_OFS    = 16'h6380;
  localparam logic [15:0] PIOC_CHANGE_STAT_OFS  = 16'h6390;

  // Alias offsets added to a base address
  localparam logic [3:0]  PIOC_ALIAS_BASE       = 4'h0;
  localparam logic [3:0]  PIOC_ALIAS_CLR        = 4'h4;
  localparam logic [3:0]  PIOC_ALIAS_SET        = 4'h8;
  localparam logic [3:0]  PIOC_ALIAS_TGL        = 4'hC;

  // Reset values
  localparam logic [15:0] PIOC_DIRECTION_RST    = 16'hFFFF;
  localparam logic [15:0] PIOC_ANALOG_SEL_RST   = 16'hFFFF;
  localparam logic [15:0] PIOC_ZERO_RST         = 16'h0000;

  localparam int          PIOC_PINS             = 16;

  typedef enum logic [1:0] {
    PIOC_OP_WRITE = 2'b00,
    PIOC_OP_CLR   = 2'b01,
    PIOC_OP_SET   = 2'b11,
    PIOC_OP_TGL   = 2'b10
  } pioc_op_e;

endpackage

// ### rtl/pioc_change_detect.sv
`timescale 1ns/1ps
module pioc_change_detect #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // Pin state and control
  input  wire logic [WIDTH-1:0] pinLevel,
  input  wire logic [WIDTH-1:0] changeEnable,
  input  wire logic             pinValueRead,
  // Results
  output logic [WIDTH-1:0]      changeStatus,
  output logic                  changeIrq
);

  logic [WIDTH-1:0] refValue_q;
  logic [WIDTH-1:0] status_q;
  logic [WIDTH-1:0] mismatch;

  assign mismatch = (pinLevel ^ refValue_q) & changeEnable;

  // Reference captured at each pin-value read
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      refValue_q <= '0;
    end else if (pinValueRead) begin
      refValue_q <= pinLevel;
    end
  end

  // Mismatch sets status
  // Read restarts tracking; the captured level absorbs any change
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= '0;
    end else if (pinValueRead) begin
      status_q <= '0;
    end else begin
      status_q <= status_q | mismatch;
    end
  end

  assign changeStatus = status_q;
  assign changeIrq = |status_q;

endmodule

// ### tb/pioc_port_monitor.sv
`timescale 1ns/1ps
module pioc_port_monitor
  import pioc_pkg::*;
#(
  parameter int PINS = 16
) (
  // Clock, reset and bus
  input wire logic            mclk,
  input wire logic            rst_b,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [31:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pslverr,
  // Pins and events
  input wire logic [PINS-1:0] pinOut,
  input wire logic [PINS-1:0] pinOe,
  input wire logic [PINS-1:0] analogSelect,
  input wire logic [PINS-1:0] analogLevel,
  input wire logic            changeIrq
);
  // ****
  // Helpers
  // ****
  logic [PINS-1:0] wdLo;
  logic            pinRd;
  assign wdLo  = pwdata[PINS-1:0];
  // Pin-value read seen in its setup cycle
  assign pinRd = psel && !penable && !pwrite
                 && paddr == {16'h0000, PIOC_PIN_VALUE_OFS};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence wrAt(logic [15:0] a);
    psel && penable && pwrite && paddr == {16'h0000, a};
  endsequence
  sequence rdAt(logic [15:0] a);
    psel && penable && !pwrite && paddr == {16'h0000, a};
  endsequence
  // ****
  // Checks
  // ****
  reset_state_a: assert property ($rose(rst_b) |-> pinOe == '0
    && analogSelect == PIOC_ANALOG_SEL_RST) else $error("bad reset state");
  latch_write_a: assert property (wrAt(PIOC_OUT_LATCH_OFS)
    |=> pinOut == $past(wdLo)) else $error("latch write lost");
  pin_write_a: assert property (wrAt(PIOC_PIN_VALUE_OFS)
    |=> pinOut == $past(wdLo)) else $error("pin write not in latch");
  set_alias_a: assert property (
    wrAt(PIOC_OUT_LATCH_OFS + 16'h0008)
    |=> pinOut == ($past(pinOut) | $past(wdLo))) else $error("set alias");
  clr_alias_a: assert property (
    wrAt(PIOC_OUT_LATCH_OFS + 16'h0004)
    |=> pinOut == ($past(pinOut) & ~$past(wdLo))) else $error("clr alias");
  inv_alias_a: assert property (
    wrAt(PIOC_OUT_LATCH_OFS + 16'h000C)
    |=> pinOut == ($past(pinOut) ^ $past(wdLo))) else $error("inv alias");
  analog_zero_a: assert property (rdAt(PIOC_PIN_VALUE_OFS)
    |-> (prdata[PINS-1:0] & analogSelect & ~pinOe & ~pinOut) == '0)
    else $error("analog pin read nonzero");
  upper_zero_a: assert property (psel && penable && !pwrite
    |-> prdata[31:16] == 16'h0000) else $error("upper bits nonzero");
  unmapped_err_a: assert property (
    psel && penable && paddr[31:16] != 0
    |-> pslverr && prdata == 32'h0) else $error("unmapped access");
  status_clear_a: assert property ($fell(changeIrq)
    |-> $past(pinRd)) else $error("irq fell without pin read");
  drive_level_a: assert property ((analogLevel & pinOe)
    == (pinOut & pinOe)) else $error("analog level differs");
endmodule

// ### tb/pioc_board.sv
`timescale 1ns/1ps
module pioc_board (
  // Device side
  input  wire logic [15:0] pinOut,
  input  wire logic [15:0] pinOe,
  input  wire logic [15:0] pullDownEn,
  // Board stimulus
  input  wire logic [15:0] extDrive,
  input  wire logic [15:0] extLevel,
  output logic      [15:0] pinIn
);
  assign pinIn = (pinOe & pinOut) | (~pinOe & extDrive & extLevel)
                 | (~pinOe & ~extDrive & ~pullDownEn);
endmodule

// ### tb/pioc_port_tb.sv
`timescale 1ns/1ps
module pioc_port_tb;
  import pioc_pkg::*;
  logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic        changeIrq, errv;
  logic [31:0] paddr, pwdata, prdata, rdv;
  logic [15:0] pinIn, pinOut, pinOe, pullUpEn, pullDownEn;
  logic [15:0] analogSelect, analogLevel, extDrive, extLevel;
  int          fails, tests_run;
  pioc_port DUT (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pinIn, .pinOut, .pinOe,
    .pullUpEn, .pullDownEn, .analogSelect, .analogLevel, .changeIrq);
  pioc_board BRD (.pinOut, .pinOe, .pullDownEn, .extDrive, .extLevel,
    .pinIn);
  // ****
  // Bus tasks
  // ****
  function automatic logic [31:0] ad(logic [15:0] o, logic [3:0] k);
    return {16'h0000, o + {12'h000, k}};
  endfunction
  task automatic chk(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdv  = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [15:0] o, input logic [31:0] d);
    apb(1'b1, ad(o, 4'h0), d);
  endtask
  task automatic rdc(input logic [31:0] a, e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic s_reset();
    rdc(ad(PIOC_DIRECTION_OFS, 4'h0), {16'h0, PIOC_DIRECTION_RST});
    rdc(ad(PIOC_ANALOG_SEL_OFS, 4'h0), {16'h0, PIOC_ANALOG_SEL_RST});
    chk({16'h0, pinOe}, 32'h0);
  endtask
  task automatic s_latch();
    wr(PIOC_ANALOG_SEL_OFS, 32'hFFFF_00FF);
    chk({16'h0, analogSelect}, 32'h00FF);
    wr(PIOC_DIRECTION_OFS, 32'h0);
    wr(PIOC_OUT_LATCH_OFS, 32'hFFFF_A5C3);
    rdc(ad(PIOC_OUT_LATCH_OFS, 4'h0), 32'hA5C3);
    chk({16'h0, pinOe}, 32'hFFFF);
    chk({16'h0, analogLevel}, 32'hA5C3);
    rdc(ad(PIOC_PIN_VALUE_OFS, 4'h0), 32'hA5C3);
    wr(PIOC_PIN_VALUE_OFS, 32'h1234);
    rdc(ad(PIOC_OUT_LATCH_OFS, 4'h0), 32'h1234);
  endtask
  task automatic s_alias();
    logic [3:0]  al [3] = '{PIOC_ALIAS_CLR, PIOC_ALIAS_SET, PIOC_ALIAS_TGL};
    logic [31:0] ex [3] = '{32'h00F0, 32'h0FFF, 32'h0FF0};
    for (int k = 0; k < 3; k++) begin
      wr(PIOC_OUT_LATCH_OFS, 32'h00FF);
      apb(1'b1, ad(PIOC_OUT_LATCH_OFS, al[k]), 32'h0F0F);
      rdc(ad(PIOC_OUT_LATCH_OFS, al[k]), 32'h0);
      rdc(ad(PIOC_OUT_LATCH_OFS, 4'h0), ex[k]);
    end
  endtask
  task automatic s_open();
    wr(PIOC_OUT_LATCH_OFS, 32'h00FF);
    wr(PIOC_OPEN_DRAIN_OFS, 32'hFFFF);
    extDrive <= 16'h0001;
    rdc(ad(PIOC_OPEN_DRAIN_OFS, 4'h0), 32'hFFFF);
    chk({16'h0, pinOe}, 32'hFF00);
    rdc(ad(PIOC_PIN_VALUE_OFS, 4'h0), 32'h00FE);
    wr(PIOC_OPEN_DRAIN_OFS, 32'h0);
    wr(PIOC_OUT_LATCH_OFS, 32'h0);
    extDrive <= 16'h0000;
  endtask
  task automatic s_pulls();
    wr(PIOC_DIRECTION_OFS, 32'hFFFF);
    wr(PIOC_PULL_DOWN_OFS, 32'h0F0F);
    wr(PIOC_PULL_UP_OFS, 32'hF0F0);
    rdc(ad(PIOC_PULL_DOWN_OFS, 4'h0), 32'h0F0F);
    chk({pullUpEn, pullDownEn}, 32'hF0F0_0F0F);
    rdc(ad(PIOC_PIN_VALUE_OFS, 4'h0), 32'hF000);
    chk({16'h0, analogLevel}, 32'hF0F0);
    wr(PIOC_PULL_DOWN_OFS, 32'h0);
    wr(PIOC_PULL_UP_OFS, 32'h0);
  endtask
  task automatic s_change();
    int n;
    wr(PIOC_ANALOG_SEL_OFS, 32'h0);
    wr(PIOC_CHANGE_EN_OFS, 32'h0001);
    rdc(ad(PIOC_PIN_VALUE_OFS, 4'h0), 32'hFFFF);
    extDrive <= 16'h0003;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (changeIrq !== 1'b1 && n < 20);
    chk({31'h0, changeIrq}, 32'h1);
    rdc(ad(PIOC_CHANGE_STAT_OFS, 4'h0), 32'h0001);
    rdc(ad(PIOC_PIN_VALUE_OFS, 4'h0), 32'hFFFC);
    rdc(ad(PIOC_CHANGE_STAT_OFS, 4'h0), 32'h0);
    chk({31'h0, changeIrq}, 32'h0);
  endtask
  task automatic s_unmap();
    wr(PIOC_OUT_LATCH_OFS, 32'h00FF);
    apb(1'b1, 32'h0001_6330, 32'hFFFF);
    chk({31'h0, errv}, 32'h1);
    rdc(ad(PIOC_OUT_LATCH_OFS, 4'h0), 32'h00FF);
    chk({31'h0, errv}, 32'h0);
    rdc(ad(16'h6370, 4'h0), 32'h0);
    chk({31'h0, errv}, 32'h1);
  endtask
  task automatic close_out();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****
  // Clock, reset, sequence
  // ****
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #125000;
    fails++;
    close_out();
  end
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {extDrive, extLevel, fails, tests_run} = '0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    s_reset();
    s_latch();
    s_alias();
    s_open();
    s_pulls();
    s_change();
    s_unmap();
    close_out();
  end
endmodule
bind pioc_port pioc_port_monitor #(.PINS(PINS)) MON (.mclk, .rst_b,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .pinOut,
  .pinOe, .analogSelect, .analogLevel, .changeIrq);
